// ===== acq_timing.sv
// Acquisition wait status, trigger judging, event flags and exposure/readout/transmit sequencing
//
// Behaviour
// [R1] Wait status only in standard mode
// [R2] Wait status rises on entering acquisition wait
// [R3] Wait status falls when trigger taken
// [R4] Trigger while not waiting: ignored, overtrigger
// [R5] Wait status needs hardware acquisition triggering
// [R6] Wait status routable to lines 1-4
// [R7] Acquisition, frame start, exposure end events
// [R8] Trigger input role follows mode; rising edge
// [R9] Fixed delay from trigger to exposure
// [R10] Debounce time added to start delay
// [R11] Readout starts when exposure time elapses
// [R12] Transmit only after enough buffered data
// [R13] Readout = (height+1)*line + frame constant
// [R14] Transmission never shorter than readout
// [R15] Events held in sticky clearable flags
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module acq_timing
	import acq_timing_pkg::*;
#(
	parameter int START_DELAY_CYCLES = START_DELAY_CYC,
	parameter int LINE_CYCLES        = LINE_CYC,
	parameter int FRAME_CYCLES       = FRAME_OVERHEAD_CYC,
	parameter int FRAME_COUNT        = 3
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// Trigger pins
	input  wire logic        ext_acq_start_trigger,
	input  wire logic        ext_trigger_input,
	// Output lines and status
	output logic      [3:0]  out_line,
	output logic             acq_wait,
	output logic             exposing,
	output logic             transmitting,
	output logic             irq
);
	initial begin
		// The frame counter is eight bits wide
		if (START_DELAY_CYCLES < 1 || FRAME_COUNT < 1 || FRAME_COUNT > 255)
			$error("acq_timing parameters out of range");
	end

	// ****************************************
	// Registers
	// ****************************************
	logic [CTRL_W-1:0] ctrl;
	logic [EV_W-1:0]   events;
	logic [EV_W-1:0]   mask;
	logic [31:0]       exposure_cycles;
	logic [31:0]       debounce_cycles;
	logic [15:0]       region_height;
	logic [31:0]       xmit_cycles;
	logic [15:0]       fill_lines;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
		return a == ref_addr;
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl            <= CTRL_RESET;
			mask            <= EV_RESET;
			exposure_cycles <= EXPOSURE_RESET;
			debounce_cycles <= 32'h0;
			region_height   <= HEIGHT_RESET;
			xmit_cycles     <= XMIT_RESET;
			fill_lines      <= FILL_RESET;
		end else if (wr) begin
			if (hit(addr, ADDR_CTRL))     ctrl            <= wdata[CTRL_W-1:0]; // see [R6]
			if (hit(addr, ADDR_MASK))     mask            <= wdata[EV_W-1:0];
			if (hit(addr, ADDR_EXPOSURE)) exposure_cycles <= wdata;
			if (hit(addr, ADDR_DEBOUNCE)) debounce_cycles <= wdata;
			if (hit(addr, ADDR_HEIGHT))   region_height   <= wdata[15:0];
			if (hit(addr, ADDR_XMIT))     xmit_cycles     <= wdata;
			if (hit(addr, ADDR_FILL))     fill_lines      <= wdata[15:0];
		end
	end

	wire standard = ctrl[CTRL_STANDARD];
	wire hw_acq   = ctrl[CTRL_HW_ACQ];

	// ****************************************
	// Pin synchronisers and edge detect
	// ****************************************
	logic [1:0] acq_sync;
	logic [1:0] trg_sync;
	logic       acq_prev;
	// Edge history starts low, the idle level of both pins, so reset makes no false edge
	logic       trg_prev;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acq_sync <= 2'h0;
			trg_sync <= 2'h0;
			acq_prev <= 1'b0;
			trg_prev <= 1'b0;
		end else begin
			acq_sync <= {acq_sync[0], ext_acq_start_trigger};
			trg_sync <= {trg_sync[0], ext_trigger_input};
			acq_prev <= acq_sync[1];
			trg_prev <= trg_sync[1];
		end
	end

	wire trg_rise = trg_sync[1] && !trg_prev; // see [R8]
	// Legacy mode: the trigger input itself acts as acquisition start
	wire acq_rise = standard ? (acq_sync[1] && !acq_prev) : trg_rise; // see [R8]

	// ****************************************
	// Acquisition sequencer
	// ****************************************
	acq_state_t  state;
	logic [31:0] cnt;
	logic [7:0]  frames_left;
	logic        readout_start;
	logic        readout_busy;
	logic        readout_done;
	logic        line_done;

	wire waiting    = (state == ST_WAIT_ACQ);
	wire acq_taken  = acq_rise && waiting;
	wire overtrig   = acq_rise && !waiting; // see [R4]
	// Standard mode: frame starts come from the trigger input; legacy runs frames internally
	wire frame_trig = standard ? trg_rise : 1'b1;
	wire frame_go   = (state == ST_WAIT_FRAME) && frame_trig && !readout_busy;
	wire expose_end = (state == ST_EXPOSE) && (cnt == 32'h0);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state       <= ST_WAIT_ACQ;
			cnt         <= 32'h0;
			frames_left <= 8'h0;
		end else begin
			unique case (state)
				ST_WAIT_ACQ: begin
					if (acq_taken) begin // see [R3]
						state       <= ST_WAIT_FRAME;
						frames_left <= 8'(FRAME_COUNT);
					end
				end
				ST_WAIT_FRAME: begin
					if (frame_go) begin
						state <= ST_DELAY;
						cnt   <= 32'(START_DELAY_CYCLES - 1) + debounce_cycles; // see [R9] see [R10]
					end
				end
				ST_DELAY: begin
					if (cnt == 32'h0) begin
						state <= ST_EXPOSE;
						cnt   <= (exposure_cycles == 32'h0) ? 32'h0 : exposure_cycles - 32'h1;
					end else begin
						cnt <= cnt - 32'h1;
					end
				end
				ST_EXPOSE: begin
					if (cnt == 32'h0) begin
						state <= ST_READOUT; // see [R11]
					end else begin
						cnt <= cnt - 32'h1;
					end
				end
				ST_READOUT: begin
					// Readout overlaps the next frame's exposure wait
					frames_left <= frames_left - 8'h1;
					state       <= (frames_left == 8'h1) ? ST_WAIT_ACQ : ST_WAIT_FRAME; // see [R2]
				end
				// Unused codes fall back to the idle wait
				default: begin
					state <= ST_WAIT_ACQ;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			readout_start <= 1'b0;
		else
			readout_start <= expose_end; // see [R11]
	end

	readout_line_timer #(
		.LINE_CYCLES  (LINE_CYCLES),
		.FRAME_CYCLES (FRAME_CYCLES)
	) u_readout (
		.clk       (clk),
		.rst       (rst),
		.start     (readout_start),
		.height    (region_height),
		.line_done (line_done),
		.busy      (readout_busy),
		.done      (readout_done)
	);

	// ****************************************
	// Transmission from frame buffer
	// ****************************************
	logic [15:0] lines_buffered;
	logic [31:0] xmit_cnt;
	logic        xmit_wait_ro;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lines_buffered <= 16'h0;
			transmitting   <= 1'b0;
			xmit_cnt       <= 32'h0;
			xmit_wait_ro   <= 1'b0;
		end else begin
			if (readout_start)
				lines_buffered <= 16'h0;
			else if (line_done)
				lines_buffered <= lines_buffered + 16'h1;
			if (!transmitting) begin
				// Start once the fill level guards against underrun (see [R12])
				// Limitation: a fill level above height + 1 never starts a transmission
				if (readout_busy && line_done && (lines_buffered + 16'h1 >= fill_lines)) begin
					transmitting <= 1'b1;
					xmit_cnt     <= xmit_cycles;
					xmit_wait_ro <= 1'b1;
				end
			end else begin
				if (readout_done)
					xmit_wait_ro <= 1'b0;
				if (xmit_cnt != 32'h0)
					xmit_cnt <= xmit_cnt - 32'h1;
				// Never finish ahead of readout (see [R14])
				else if (!xmit_wait_ro && !readout_done)
					transmitting <= 1'b0;
			end
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	wire wait_level = waiting && standard && hw_acq; // see [R1] see [R5]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acq_wait <= 1'b0;
			out_line <= 4'h0;
			exposing <= 1'b0;
		end else begin
			acq_wait <= wait_level; // see [R2] see [R3]
			// Follows the state being entered, so the level lasts the full exposure count
			exposing <= ((state == ST_DELAY) && (cnt == 32'h0)) || ((state == ST_EXPOSE) && !expose_end); // see [R11]
			for (int i = 0; i < 4; i++)
				out_line[i] <= ctrl[CTRL_ROUTE_EN] && (ctrl[CTRL_LINE_LO +: 2] == 2'(i)) && wait_level; // see [R6]
		end
	end

	// ****************************************
	// Event flags and interrupt
	// ****************************************
	logic [EV_W-1:0] ev_set;
	always_comb begin
		ev_set                  = '0;
		ev_set[EV_ACQ_START]    = acq_taken;  // see [R7]
		ev_set[EV_FRAME_START]  = frame_go;   // see [R7]
		ev_set[EV_EXPOSURE_END] = expose_end; // see [R7]
		ev_set[EV_OVERTRIGGER]  = overtrig;   // see [R4]
	end

	wire [EV_W-1:0] ev_clr = (wr && hit(addr, ADDR_EVENTS)) ? wdata[EV_W-1:0] : '0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			events <= EV_RESET;
			irq    <= 1'b0;
		end else begin
			events <= (events & ~ev_clr) | ev_set; // see [R15]
			irq    <= |(((events & ~ev_clr) | ev_set) & mask);
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0;
		end else if (rd) begin
			unique case (addr)
				ADDR_CTRL:     rdata <= 32'(ctrl);
				ADDR_STATUS:   rdata <= {25'h0, transmitting, readout_busy, exposing, acq_wait, state};
				ADDR_EVENTS:   rdata <= 32'(events);
				ADDR_MASK:     rdata <= 32'(mask);
				ADDR_EXPOSURE: rdata <= exposure_cycles;
				ADDR_DEBOUNCE: rdata <= debounce_cycles;
				ADDR_HEIGHT:   rdata <= 32'(region_height);
				ADDR_XMIT:     rdata <= xmit_cycles;
				ADDR_FILL:     rdata <= 32'(fill_lines);
				default:       rdata <= 32'h0;
			endcase
		end else begin
			rdata <= 32'h0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_wait_mode: assert property (@(posedge clk) disable iff (rst) acq_wait |-> $past(standard && hw_acq)) // see [R1]
		else $error("wait status outside standard hardware mode");
	chk_wait_rise: assert property (@(posedge clk) disable iff (rst) wait_level |=> acq_wait) // see [R2]
		else $error("wait status did not rise");
	chk_wait_fall: assert property (@(posedge clk) disable iff (rst) acq_taken |=> ##1 !acq_wait) // see [R3]
		else $error("wait status did not fall after trigger");
	// An ignored trigger must not reload the frame count
	chk_overtrig_flag: assert property (@(posedge clk) disable iff (rst) overtrig |=> events[EV_OVERTRIGGER] && frames_left == $past(frames_left) - (($past(state) == ST_READOUT) ? 8'h1 : 8'h0)) // see [R4]
		else $error("overtrigger not flagged or not ignored");
	chk_route_line: assert property (@(posedge clk) disable iff (rst) $rose(out_line[0]) |-> $past(ctrl[CTRL_LINE_LO +: 2]) == 2'h0) // see [R6]
		else $error("wait status on unselected line");
	chk_exp_event: assert property (@(posedge clk) disable iff (rst) expose_end |=> events[EV_EXPOSURE_END] ##1 readout_busy) // see [R7]
		else $error("exposure end not flagged");
	chk_start_delay: assert property (@(posedge clk) disable iff (rst) frame_go |=> state == ST_DELAY && cnt == 32'(START_DELAY_CYCLES - 1) + $past(debounce_cycles)) // see [R9] see [R10]
		else $error("exposure start delay wrong");
	chk_frame_hold: assert property (@(posedge clk) disable iff (rst) state == ST_WAIT_FRAME && readout_busy |=> state == ST_WAIT_FRAME) // see [R8]
		else $error("frame started during readout");
	chk_xmit_fill: assert property (@(posedge clk) disable iff (rst) $rose(transmitting) |-> $past(readout_busy && (lines_buffered + 16'h1 >= fill_lines))) // see [R12]
		else $error("transmission started before fill level");
	chk_xmit_ro: assert property (@(posedge clk) disable iff (rst) $fell(transmitting) |-> !readout_busy) // see [R14]
		else $error("transmission ended before readout");
	chk_flag_hold: assert property (@(posedge clk) disable iff (rst) events[EV_ACQ_START] && !ev_clr[EV_ACQ_START] |=> events[EV_ACQ_START]) // see [R15]
		else $error("event flag lost");

	cov_overtrig: cover property (@(posedge clk) disable iff (rst) overtrig);
	cov_full_seq: cover property (@(posedge clk) disable iff (rst) acq_taken ##[1:1000] expose_end);
	cov_xmit: cover property (@(posedge clk) disable iff (rst) $fell(transmitting));
	cov_legacy_acq: cover property (@(posedge clk) disable iff (rst) !standard && acq_taken);
	cov_route_last: cover property (@(posedge clk) disable iff (rst) $rose(out_line[3]));
endmodule
`default_nettype wire

// ===== acq_timing_pkg.sv
// Package: register map, field positions, reset values and timing constants of the acquisition timing block
package acq_timing_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_EVENTS   = 8'h08;
	localparam logic [7:0] ADDR_MASK     = 8'h0C;
	localparam logic [7:0] ADDR_EXPOSURE = 8'h10;
	localparam logic [7:0] ADDR_DEBOUNCE = 8'h14;
	localparam logic [7:0] ADDR_HEIGHT   = 8'h18;
	localparam logic [7:0] ADDR_XMIT     = 8'h1C;
	localparam logic [7:0] ADDR_FILL     = 8'h20;

	// ****************************************
	// Control fields
	// ****************************************
	localparam int CTRL_STANDARD = 0;
	localparam int CTRL_HW_ACQ   = 1;
	localparam int CTRL_LINE_LO  = 2;
	localparam int CTRL_ROUTE_EN = 4;
	localparam int CTRL_W        = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h03;

	// ****************************************
	// Event bits
	// ****************************************
	localparam int EV_ACQ_START  = 0;
	localparam int EV_FRAME_START = 1;
	localparam int EV_EXPOSURE_END = 2;
	localparam int EV_OVERTRIGGER = 3;
	localparam int EV_W          = 4;
	localparam logic [EV_W-1:0] EV_RESET = 4'h0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ                = 25_000_000;
	localparam int START_DELAY_NS        = 33_800;
	localparam int START_DELAY_CYC       = (START_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int LINE_TIME_NS          = 25_490;
	localparam int LINE_CYC              = (LINE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int FRAME_OVERHEAD_NS     = 1_612_860;
	localparam int FRAME_OVERHEAD_CYC    = (FRAME_OVERHEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [31:0] EXPOSURE_RESET = 32'h0000_0100;
	localparam logic [15:0] HEIGHT_RESET   = 16'h0010;
	localparam logic [31:0] XMIT_RESET     = 32'h0000_0200;
	localparam logic [15:0] FILL_RESET     = 16'h0008;

	typedef enum logic [2:0] {ST_WAIT_ACQ, ST_WAIT_FRAME, ST_DELAY, ST_EXPOSE, ST_READOUT} acq_state_t;

endpackage

// ===== readout_line_timer.sv
// Line-paced sensor readout timer with per-line done pulses and an end-of-readout pulse
`timescale 1ns/1ps
`default_nettype none
module readout_line_timer
	import acq_timing_pkg::*;
#(
	parameter int LINE_CYCLES  = LINE_CYC,
	parameter int FRAME_CYCLES = FRAME_OVERHEAD_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Control
	input  wire logic        start,
	input  wire logic [15:0] height,
	// Progress
	output logic             line_done,
	output logic             busy,
	output logic             done
);
	initial begin
		if (LINE_CYCLES < 1 || FRAME_CYCLES < 1)
			$error("readout timer counts must be positive");
	end

	logic [31:0] cnt;
	logic [16:0] lines_left;
	logic        tail;

	// Readout = (height + 1) line periods, then the per-frame overhead (see [R13])
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt        <= 32'h0;
			lines_left <= 17'h0;
			tail       <= 1'b0;
			busy       <= 1'b0;
			done       <= 1'b0;
			line_done  <= 1'b0;
		end else begin
			done      <= 1'b0;
			line_done <= 1'b0;
			if (start && !busy) begin
				busy       <= 1'b1;
				tail       <= 1'b0;
				lines_left <= {1'b0, height} + 17'h1;
				cnt        <= 32'(LINE_CYCLES - 1);
			end else if (busy) begin
				if (cnt != 32'h0) begin
					cnt <= cnt - 32'h1;
				end else if (!tail) begin
					line_done  <= 1'b1;
					lines_left <= lines_left - 17'h1;
					if (lines_left == 17'h1) begin
						tail <= 1'b1;
						cnt  <= 32'(FRAME_CYCLES - 1);
					end else begin
						cnt <= 32'(LINE_CYCLES - 1);
					end
				end else begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== trig_source.sv
// Partner model: external trigger source that drives the two trigger pins
`timescale 1ns/1ps
`default_nettype none
module trig_source (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Commands from the bench
	input  wire logic fire_acq,
	input  wire logic fire_frame,
	// Trigger pins
	output logic      acq_pin,
	output logic      frame_pin
);
	logic [2:0] acq_hold;
	logic [2:0] frame_hold;

	// Pulses last four cycles so that the two-flop synchroniser cannot miss them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acq_hold <= 3'h0;
		end else if (fire_acq) begin
			acq_hold <= 3'h4;
		end else if (acq_hold != 3'h0) begin
			acq_hold <= acq_hold - 3'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_hold <= 3'h0;
		end else if (fire_frame) begin
			frame_hold <= 3'h4;
		end else if (frame_hold != 3'h0) begin
			frame_hold <= frame_hold - 3'h1;
		end
	end

	// A pin rests low between pulses; a command while the pin is low yields a single rising edge, one during a pulse only extends it
	assign acq_pin   = (acq_hold != 3'h0);
	assign frame_pin = (frame_hold != 3'h0);
endmodule
`default_nettype wire

// ===== tb_top.sv
// Testbench: register, trigger, event and frame timing scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import acq_timing_pkg::*;
;
	localparam int SD  = 4;
	localparam int LC  = 2;
	localparam int FC  = 5;
	localparam int EXP = 6;
	localparam int DEB = 3;
	localparam int HT  = 2;
	localparam int XM  = 4;
	localparam int FL  = 1;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        fire_acq = 1'b0;
	logic        fire_frame = 1'b0;
	wire logic   acq_pin;
	wire logic   frame_pin;
	logic [3:0]  out_line;
	logic        acq_wait;
	logic        exposing;
	logic        transmitting;
	logic        irq;
	int          bad_count = 0;
	int          samples_checked = 0;

	acq_timing #(.START_DELAY_CYCLES(SD), .LINE_CYCLES(LC), .FRAME_CYCLES(FC), .FRAME_COUNT(3)) u_acq_timing (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ext_acq_start_trigger(acq_pin), .ext_trigger_input(frame_pin), .out_line(out_line),
		.acq_wait(acq_wait), .exposing(exposing), .transmitting(transmitting), .irq(irq));
	trig_source u_trig_source (.clk(clk), .rst(rst), .fire_acq(fire_acq), .fire_frame(fire_frame),
		.acq_pin(acq_pin), .frame_pin(frame_pin));

	initial begin
		forever #20 clk = ~clk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (exp !== got) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Bounded wait: 0 acq_wait, 1 exposing, 2 transmitting; n counts the cycles waited
	task automatic wait_for(input int sel, input logic v, output int n);
		logic s;
		for (n = 0; n < 500; n++) begin
			s = (sel == 0) ? acq_wait : (sel == 1) ? exposing : transmitting;
			if (s === v) begin
				return;
			end
			settle(1);
		end
		bad_count++;
		$display("Error wait %0d expected %b seen timeout", sel, v);
		wrap_up();
	endtask

	task automatic fire(input logic frame);
		@(posedge clk);
		if (frame) fire_frame <= 1'b1;
		else fire_acq <= 1'b1;
		@(posedge clk);
		fire_frame <= 1'b0;
		fire_acq <= 1'b0;
		#1;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		logic [31:0] d;
		rreg(ADDR_CTRL, d);
		check("ctrl", {27'h0, CTRL_RESET}, d);
		// Idle wait has the first state code; only the wait status bit is up
		rreg(ADDR_STATUS, d);
		check("status", 32'h8, d);
		rreg(ADDR_EVENTS, d);
		check("events", {28'h0, EV_RESET}, d);
		rreg(ADDR_MASK, d);
		check("mask", {28'h0, EV_RESET}, d);
		rreg(ADDR_EXPOSURE, d);
		check("exposure", EXPOSURE_RESET, d);
		rreg(ADDR_HEIGHT, d);
		check("height", {16'h0, HEIGHT_RESET}, d);
		rreg(ADDR_XMIT, d);
		check("xmit", XMIT_RESET, d);
		rreg(ADDR_FILL, d);
		check("fill", {16'h0, FILL_RESET}, d);
		rreg(8'h40, d);
		check("unmapped", 32'h0, d);
		check("acq_wait", 32'h1, {31'h0, acq_wait});
	endtask

	task automatic t_modes;
		int n;
		wreg(ADDR_CTRL, 32'h02);
		settle(3);
		check("acq_wait legacy", 32'h0, {31'h0, acq_wait});
		wreg(ADDR_CTRL, 32'h01);
		settle(3);
		check("acq_wait sw", 32'h0, {31'h0, acq_wait});
		wreg(ADDR_CTRL, 32'h03);
		wait_for(0, 1'b1, n);
		check("acq_wait back", 32'h1, {31'h0, (n <= 4)});
	endtask

	task automatic t_route;
		for (int i = 0; i < 4; i++) begin
			wreg(ADDR_CTRL, 32'h13 | (i << 2));
			settle(3);
			check("out_line", 32'h1 << i, {28'h0, out_line});
		end
		wreg(ADDR_CTRL, 32'h03);
		settle(3);
		check("out_line off", 32'h0, {28'h0, out_line});
	endtask

	task automatic t_frame;
		int n;
		int m;
		int k;
		fire(1'b1);
		wait_for(1, 1'b1, n);
		// Two to four cycles of pin synchroniser and edge detect precede the start delay
		check("start delay", 32'h1, {31'h0, (n >= SD + DEB + 2 && n <= SD + DEB + 4)});
		wait_for(1, 1'b0, n);
		check("exposure len", EXP, n);
		wait_for(2, 1'b1, m);
		check("xmit start", 32'h1, {31'h0, (m >= FL * LC)});
		wait_for(2, 1'b0, k);
		check("readout floor", 32'h1, {31'h0, (m + k >= (HT + 1) * LC + FC)});
		check("xmit floor", 32'h1, {31'h0, (k >= XM)});
	endtask

	task automatic t_acquire;
		logic [31:0] d;
		int n;
		wreg(ADDR_EXPOSURE, EXP);
		wreg(ADDR_DEBOUNCE, DEB);
		wreg(ADDR_HEIGHT, HT);
		wreg(ADDR_XMIT, XM);
		wreg(ADDR_FILL, FL);
		wreg(ADDR_MASK, 32'h0);
		fire(1'b0);
		wait_for(0, 1'b0, n);
		check("acq_wait fall", 32'h1, {31'h0, (n <= 8)});
		rreg(ADDR_EVENTS, d);
		check("acq event", 32'h1, d);
		fire(1'b0);
		settle(8);
		rreg(ADDR_EVENTS, d);
		check("overtrigger", 32'h9, d);
		check("still busy", 32'h0, {31'h0, acq_wait});
		for (int f = 0; f < 3; f++) begin
			t_frame();
		end
		wait_for(0, 1'b1, n);
		rreg(ADDR_EVENTS, d);
		check("all events", 32'hF, d);
	endtask

	task automatic t_irq;
		logic [31:0] d;
		settle(2);
		check("irq masked", 32'h0, {31'h0, irq});
		wreg(ADDR_MASK, 32'h8);
		settle(2);
		check("irq set", 32'h1, {31'h0, irq});
		wreg(ADDR_EVENTS, 32'hF);
		settle(2);
		check("irq clear", 32'h0, {31'h0, irq});
		rreg(ADDR_EVENTS, d);
		check("events cleared", 32'h0, d);
	endtask

	// Legacy mode: the frame pin now starts the acquisition
	task automatic t_legacy;
		logic [31:0] d;
		wreg(ADDR_CTRL, 32'h02);
		fire(1'b1);
		settle(8);
		rreg(ADDR_EVENTS, d);
		check("legacy acq event", 32'h1, d & 32'h1);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		settle(2);
		t_reset();
		t_modes();
		t_route();
		t_acquire();
		t_irq();
		t_legacy();
		wrap_up();
	end
endmodule
`default_nettype wire
